// ==== pc_stack_consts.vh ====
// Register offsets, field positions, reset values and vectors of the PC and return stack block
`ifndef PC_STACK_CONSTS_VH
`define PC_STACK_CONSTS_VH

`define PC_WIDTH            21
`define PC_STEP             21'h000002
`define PC_RESET            21'h000000
`define VECTOR_HIGH_PRIO    21'h000008
`define VECTOR_LOW_PRIO     21'h000018

`define STACK_DEPTH         5'h1F
`define POS_WIDTH           5
`define POS_EMPTY           5'h00

`define ADDR_WIDTH          12
`define OFF_PC_LOW          12'h000
`define OFF_PC_HIGH_LATCH   12'h004
`define OFF_PC_UPPER_LATCH  12'h008
`define OFF_STACK_POINTER   12'h00C
`define OFF_TOP_LOW         12'h010
`define OFF_TOP_HIGH        12'h014
`define OFF_TOP_UPPER       12'h018

`define SEL_PC_LOW          3'h0
`define SEL_HIGH_LATCH      3'h1
`define SEL_UPPER_LATCH     3'h2
`define SEL_POINTER         3'h3
`define SEL_TOP_LOW         3'h4
`define SEL_TOP_HIGH        3'h5
`define SEL_TOP_UPPER       3'h6
`define SEL_NONE            3'h7

`define PTR_FULL_BIT        7
`define PTR_UNF_BIT         6
`define LATCH_RESET         8'h00

`endif

// ==== return_stack_ram.v ====
// Return stack storage: 31 words of 21 bits, position zero has no storage
`timescale 1ns/1ps
`include "pc_stack_consts.vh"

module return_stack_ram (
  input  wire        sys_clk,
  input  wire        wrEn,
  input  wire [4:0]  wrPos,
  input  wire [20:0] wrData,
  input  wire [4:0]  rdPos,
  output wire [20:0] rdData
);

  reg [20:0] words [1:31];

  // Position zero reads as zero and swallows writes
  assign rdData = (rdPos == `POS_EMPTY) ? `PC_RESET : words[rdPos];

  always @(posedge sys_clk) begin
    if (wrEn && (wrPos != `POS_EMPTY)) begin
      words[wrPos] <= wrData;
    end
  end

endmodule

// ==== program_counter_return_stack.v ====
// Program counter, return address stack and fast shadow stack with an APB register slave
//
// Operation
// - Program counter is 21 bits held as low, high and upper bytes.
// - Low byte read/write by software; high byte only through high latch.
// - Upper byte holds bits 20..16, updated only through upper latch.
// - Writing the low byte copies both latches into the counter.
// - Reading the low byte copies counter high and upper bytes into latches.
// - Bit zero stays zero; sequential advance adds two.
// - Calls, jumps and branches load the counter without using latches.
// - Up to 31 entries; push on call or interrupt, pop on returns.
// - Calls and returns leave both latches unchanged.
// - Stack is 31 words of 21 bits with a 5-bit pointer.
// - Push increments then writes; pop reads then decrements.
// - Every reset clears the pointer; position zero has no storage.
// - Software reaches only the top entry via three byte registers, and the pointer.
// - Full flag sets after 31 pushes; cleared only by software or power-on.
// - Reset-enable set: 31st push stores, sets full, resets device, pointer zero.
// - Reset-enable clear: pointer stays 31, further pushes do not overwrite.
// - Empty return loads zero; any empty pop sets underflow, pointer stays zero.
// - Full or underflow always flags; device reset only when enabled.
// - Push instruction stores current counter; pop instruction only decrements.
// - Interrupt vectoring loads shadow status, working and bank-select copies.
// - Fast interrupt return restores the three registers from shadow.
// - Fast call saves into shadow; fast return restores from it.
// - Interrupt loads vector 0008h or 0018h into the counter.
`timescale 1ns/1ps
`include "pc_stack_consts.vh"

module program_counter_return_stack (
  input  wire        sys_clk,
  input  wire        rstn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Core sequencing strobes, one operation per cycle
  input  wire        seqAdvance,
  input  wire        jumpLoad,
  input  wire [20:0] jumpTarget,
  input  wire        callReq,
  input  wire        returnReq,
  input  wire        fastOption,
  input  wire        pushInstr,
  input  wire        popInstr,
  input  wire        intAck,
  input  wire        intHighPriority,
  input  wire        stackOverflowResetEnable,
  input  wire [7:0]  statusIn,
  input  wire [7:0]  workingIn,
  input  wire [7:0]  bankSelectIn,
  // Results
  output reg  [20:0] programCounter,
  output reg         restoreValid,
  output reg  [7:0]  statusRestore,
  output reg  [7:0]  workingRestore,
  output reg  [7:0]  bankSelectRestore,
  output reg         stackDeviceReset,
  output reg         stackFullFlag,
  output reg         stackUnderflowFlag
);

  reg  [7:0]  pcHighLatch_reg;
  reg  [4:0]  pcUpperLatch_reg;
  reg  [4:0]  stackPosition_reg;
  reg  [7:0]  shadowStatus_reg;
  reg  [7:0]  shadowWorking_reg;
  reg  [7:0]  shadowBank_reg;

  wire [20:0] stackTopEntry;
  reg         ramWrEn;
  reg  [4:0]  ramWrPos;
  reg  [20:0] ramWrData;
  reg  [20:0] programCounter_next;
  reg  [4:0]  stackPosition_next;
  reg  [7:0]  pcHighLatch_next;
  reg  [4:0]  pcUpperLatch_next;
  reg  [31:0] readData_next;
  reg         slaveError_next;

  function [2:0] regSelect;
    input [11:0] addr;
    begin
      case (addr)
        `OFF_PC_LOW:         regSelect = `SEL_PC_LOW;
        `OFF_PC_HIGH_LATCH:  regSelect = `SEL_HIGH_LATCH;
        `OFF_PC_UPPER_LATCH: regSelect = `SEL_UPPER_LATCH;
        `OFF_STACK_POINTER:  regSelect = `SEL_POINTER;
        `OFF_TOP_LOW:        regSelect = `SEL_TOP_LOW;
        `OFF_TOP_HIGH:       regSelect = `SEL_TOP_HIGH;
        `OFF_TOP_UPPER:      regSelect = `SEL_TOP_UPPER;
        default:             regSelect = `SEL_NONE;
      endcase
    end
  endfunction

  // Sticky flag update shared by both stack flags; the event beats a clear
  function stickyNext;
    input setEvent;
    input current;
    input clearReq;
    begin
      stickyNext = setEvent | (current & ~clearReq);
    end
  endfunction

  wire [2:0]  busSel   = regSelect(paddr);
  wire        busSetup = psel & ~penable;
  wire        busWr    = psel & penable & pwrite & pready;
  wire        busRd    = psel & penable & ~pwrite & pready;

  // One core operation per cycle, interrupt acknowledge first
  wire doInt    = intAck;
  wire doCall   = ~intAck & callReq;
  wire doRet    = ~intAck & ~callReq & returnReq;
  wire doPushI  = ~intAck & ~callReq & ~returnReq & pushInstr;
  wire doPopI   = ~intAck & ~callReq & ~returnReq & ~pushInstr & popInstr;
  wire doJump   = ~intAck & ~callReq & ~returnReq & ~pushInstr & ~popInstr & jumpLoad;
  wire doSeq    = ~intAck & ~callReq & ~returnReq & ~pushInstr & ~popInstr & ~jumpLoad & seqAdvance;
  wire anyPush  = doInt | doCall | doPushI;
  wire anyPop   = doRet | doPopI;
  wire coreUsesStack = anyPush | anyPop;

  wire [20:0] pcPlusStep = programCounter + `PC_STEP;
  // Call pushes the address after the call; interrupt and push instruction the current one
  wire [20:0] pushValue  = doCall ? pcPlusStep : programCounter;

  wire stackAtTop   = (stackPosition_reg == `STACK_DEPTH);
  wire stackEmpty   = (stackPosition_reg == `POS_EMPTY);
  wire [4:0] posUp  = stackPosition_reg + 5'h01;
  wire [4:0] posDn  = stackPosition_reg - 5'h01;
  wire pushReachesTop = anyPush & (posUp == `STACK_DEPTH) & ~stackAtTop;
  wire pushBeyondTop  = anyPush & stackAtTop;
  wire setFull        = pushReachesTop | pushBeyondTop;
  wire setUnderflow   = anyPop & stackEmpty;
  // Device reset only on the 31st push and on underflow when enabled
  wire triggerReset   = stackOverflowResetEnable & (pushReachesTop | setUnderflow);

  // Top-of-stack byte writes merge into the selected entry; core stack use wins
  wire busTopWr = busWr & ~coreUsesStack & ~stackEmpty &
                  ((busSel == `SEL_TOP_LOW) | (busSel == `SEL_TOP_HIGH) | (busSel == `SEL_TOP_UPPER));

  always @* begin
    ramWrEn   = 1'b0;
    ramWrPos  = posUp;
    ramWrData = pushValue;
    if (anyPush && !stackAtTop) begin
      ramWrEn = 1'b1;
    end else if (busTopWr) begin
      ramWrEn  = 1'b1;
      ramWrPos = stackPosition_reg;
      case (busSel)
        `SEL_TOP_LOW:  ramWrData = {stackTopEntry[20:8], pwdata[7:0]};
        `SEL_TOP_HIGH: ramWrData = {stackTopEntry[20:16], pwdata[7:0], stackTopEntry[7:0]};
        default:       ramWrData = {pwdata[4:0], stackTopEntry[15:0]};
      endcase
    end
  end

  return_stack_ram stackRam (
    .sys_clk (sys_clk),
    .wrEn    (ramWrEn),
    .wrPos   (ramWrPos),
    .wrData  (ramWrData),
    .rdPos   (stackPosition_reg),
    .rdData  (stackTopEntry)
  );

  // Software clears a flag with a zero write; a one leaves it alone
  wire busPtrWr      = busWr & (busSel == `SEL_POINTER);
  wire fullClear     = busPtrWr & ~pwdata[`PTR_FULL_BIT];
  wire underClear    = busPtrWr & ~pwdata[`PTR_UNF_BIT];
  wire fullNext      = stickyNext(setFull, stackFullFlag, fullClear);
  wire underNext     = stickyNext(setUnderflow, stackUnderflowFlag, underClear);

  wire busPcLowWr    = busWr & (busSel == `SEL_PC_LOW);
  wire busPcLowRd    = busRd & (busSel == `SEL_PC_LOW);

  // Flags survive a stack-triggered device reset; only rstn or a software zero write clears them
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stackFullFlag      <= 1'b0;
      stackUnderflowFlag <= 1'b0;
    end else begin
      stackFullFlag      <= fullNext;
      stackUnderflowFlag <= underNext;
    end
  end

  // Next counter; a stack-triggered reset overrides every other source
  always @* begin
    programCounter_next = programCounter;
    if (triggerReset) begin
      programCounter_next = `PC_RESET;
    end else if (doInt) begin
      programCounter_next = intHighPriority ? `VECTOR_HIGH_PRIO : `VECTOR_LOW_PRIO;
    end else if (doCall || doJump) begin
      programCounter_next = {jumpTarget[20:1], 1'b0};
    end else if (doRet) begin
      // Empty stack returns zero from position zero
      programCounter_next = {stackTopEntry[20:1], 1'b0};
    end else if (busPcLowWr) begin
      programCounter_next = {pcUpperLatch_reg, pcHighLatch_reg, pwdata[7:1], 1'b0};
    end else if (doSeq || doPushI || doPopI) begin
      programCounter_next = {pcPlusStep[20:1], 1'b0};
    end
  end

  // Next pointer; pushes stop at the top, pops stop at empty
  always @* begin
    stackPosition_next = stackPosition_reg;
    if (triggerReset) begin
      stackPosition_next = `POS_EMPTY;
    end else if (anyPush) begin
      if (!stackAtTop) begin
        stackPosition_next = posUp;
      end
    end else if (anyPop) begin
      if (!stackEmpty) begin
        stackPosition_next = posDn;
      end
    end else if (busPtrWr) begin
      stackPosition_next = pwdata[4:0];
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      programCounter    <= `PC_RESET;
      stackPosition_reg <= `POS_EMPTY;
      stackDeviceReset  <= 1'b0;
    end else begin
      programCounter    <= programCounter_next;
      stackPosition_reg <= stackPosition_next;
      stackDeviceReset  <= triggerReset;
    end
  end

  // Latches move only on a software read of the low byte or a software write to the latch itself
  always @* begin
    pcHighLatch_next  = pcHighLatch_reg;
    pcUpperLatch_next = pcUpperLatch_reg;
    if (busPcLowRd) begin
      pcHighLatch_next  = programCounter[15:8];
      pcUpperLatch_next = programCounter[20:16];
    end else if (busWr && busSel == `SEL_HIGH_LATCH) begin
      pcHighLatch_next  = pwdata[7:0];
    end else if (busWr && busSel == `SEL_UPPER_LATCH) begin
      pcUpperLatch_next = pwdata[4:0];
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pcHighLatch_reg  <= `LATCH_RESET;
      pcUpperLatch_reg <= 5'h00;
    end else begin
      pcHighLatch_reg  <= pcHighLatch_next;
      pcUpperLatch_reg <= pcUpperLatch_next;
    end
  end

  // Shadow stack holds one level; a nested interrupt overwrites it
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shadowStatus_reg  <= 8'h00;
      shadowWorking_reg <= 8'h00;
      shadowBank_reg    <= 8'h00;
      restoreValid      <= 1'b0;
      statusRestore     <= 8'h00;
      workingRestore    <= 8'h00;
      bankSelectRestore <= 8'h00;
    end else begin
      restoreValid <= doRet & fastOption;
      if (doInt || (doCall && fastOption)) begin
        shadowStatus_reg  <= statusIn;
        shadowWorking_reg <= workingIn;
        shadowBank_reg    <= bankSelectIn;
      end
      if (doRet && fastOption) begin
        statusRestore     <= shadowStatus_reg;
        workingRestore    <= shadowWorking_reg;
        bankSelectRestore <= shadowBank_reg;
      end
    end
  end

  // Read data is captured in the setup cycle so the access phase needs no wait
  always @* begin
    readData_next   = prdata;
    slaveError_next = pslverr;
    if (busSetup) begin
      slaveError_next = (busSel == `SEL_NONE);
      case (busSel)
        `SEL_PC_LOW:      readData_next = {24'h000000, programCounter[7:0]};
        `SEL_HIGH_LATCH:  readData_next = {24'h000000, pcHighLatch_reg};
        `SEL_UPPER_LATCH: readData_next = {27'h0000000, pcUpperLatch_reg};
        `SEL_POINTER:     readData_next = {24'h000000, fullNext, underNext, 1'b0, stackPosition_reg};
        `SEL_TOP_LOW:     readData_next = {24'h000000, stackTopEntry[7:0]};
        `SEL_TOP_HIGH:    readData_next = {24'h000000, stackTopEntry[15:8]};
        `SEL_TOP_UPPER:   readData_next = {27'h0000000, stackTopEntry[20:16]};
        default:          readData_next = 32'h00000000;
      endcase
    end
  end

  // Data and error stand until the next setup cycle
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= readData_next;
      pready  <= 1'b1;
      pslverr <= slaveError_next;
    end
  end

endmodule

// ==== program_counter_return_stack_monitor.sv ====
// Assertion checker for the program counter and return stack block
`timescale 1ns/1ps
module program_counter_return_stack_monitor (
  input wire        sys_clk,
  input wire        rstn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        seqAdvance,
  input wire        jumpLoad,
  input wire [20:0] jumpTarget,
  input wire        callReq,
  input wire        returnReq,
  input wire        fastOption,
  input wire        pushInstr,
  input wire        popInstr,
  input wire        intAck,
  input wire        intHighPriority,
  input wire        stackOverflowResetEnable,
  input wire [20:0] programCounter,
  input wire        restoreValid,
  input wire        stackDeviceReset,
  input wire        stackFullFlag,
  input wire        stackUnderflowFlag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire apbWr = psel && penable && pwrite;
  wire ptrWr = apbWr && paddr == 12'h00C;
  wire busyHi = intAck || callReq || returnReq || pushInstr || popInstr;
  property p_seq;
    seqAdvance && !busyHi && !jumpLoad && !apbWr |=> programCounter == $past(programCounter) + 21'h000002;
  endproperty
  a_seq: assert property (p_seq) else $error("PC step wrong");
  property p_load;
    (jumpLoad && !busyHi) || (callReq && !intAck) |=> stackDeviceReset || programCounter == {$past(jumpTarget[20:1]), 1'b0};
  endproperty
  a_load: assert property (p_load) else $error("PC load wrong");
  property p_vec;
    intAck |=> stackDeviceReset || programCounter == ($past(intHighPriority) ? 21'h000008 : 21'h000018);
  endproperty
  a_vec: assert property (p_vec) else $error("Vector wrong");
  property p_dev;
    stackDeviceReset |-> programCounter == 21'h000000 && $past(stackOverflowResetEnable);
  endproperty
  a_dev: assert property (p_dev) else $error("Device reset wrong");
  property p_full;
    stackFullFlag && !(ptrWr && !pwdata[7]) |=> stackFullFlag;
  endproperty
  a_full: assert property (p_full) else $error("Full flag lost");
  property p_unf;
    stackUnderflowFlag && !(ptrWr && !pwdata[6]) |=> stackUnderflowFlag;
  endproperty
  a_unf: assert property (p_unf) else $error("Underflow flag lost");
  property p_noset;
    !stackFullFlag && !intAck && !callReq && !pushInstr |=> !stackFullFlag;
  endproperty
  a_noset: assert property (p_noset) else $error("Full flag set without push");
  property p_rest;
    restoreValid |-> $past(returnReq) && $past(fastOption);
  endproperty
  a_rest: assert property (p_rest) else $error("Restore without fast return");
endmodule

bind program_counter_return_stack program_counter_return_stack_monitor i_monitor (
  .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .seqAdvance(seqAdvance), .jumpLoad(jumpLoad), .jumpTarget(jumpTarget),
  .callReq(callReq), .returnReq(returnReq), .fastOption(fastOption), .pushInstr(pushInstr),
  .popInstr(popInstr), .intAck(intAck), .intHighPriority(intHighPriority),
  .stackOverflowResetEnable(stackOverflowResetEnable), .programCounter(programCounter),
  .restoreValid(restoreValid), .stackDeviceReset(stackDeviceReset), .stackFullFlag(stackFullFlag),
  .stackUnderflowFlag(stackUnderflowFlag));

// ==== program_counter_return_stack_tb.sv ====
// Self-checking bench for the program counter and return stack block
`timescale 1ns/1ps
module program_counter_return_stack_tb;
  logic        sys_clk, rstn, psel, penable, pwrite, fastOption, intHighPriority, en, pready, pslverr;
  logic        restoreValid, stackDeviceReset, stackFullFlag, stackUnderflowFlag, full, unf, rst;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [6:0]  strb;
  logic [20:0] jumpTarget, programCounter, pc, stk[0:31];
  logic [23:0] cur, sh, restoreBus;
  logic [7:0]  hiLatch, upLatch;
  integer      errors, check_count, seed, ptr, i, k;
  program_counter_return_stack i_program_counter_return_stack (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .seqAdvance(strb[0]),
    .jumpLoad(strb[1]), .jumpTarget(jumpTarget), .callReq(strb[5]), .returnReq(strb[4]),
    .fastOption(fastOption), .pushInstr(strb[3]), .popInstr(strb[2]), .intAck(strb[6]),
    .intHighPriority(intHighPriority), .stackOverflowResetEnable(en), .statusIn(cur[23:16]),
    .workingIn(cur[15:8]), .bankSelectIn(cur[7:0]), .programCounter(programCounter),
    .restoreValid(restoreValid), .statusRestore(restoreBus[23:16]), .workingRestore(restoreBus[15:8]),
    .bankSelectRestore(restoreBus[7:0]), .stackDeviceReset(stackDeviceReset),
    .stackFullFlag(stackFullFlag), .stackUnderflowFlag(stackUnderflowFlag));
  initial begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    errors++;
    results;
  end
  task results;
    $display("Checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task push(input logic [20:0] v);
    if (ptr == 31) full = 1;
    else begin
      ptr++;
      stk[ptr] = v;
      if (ptr == 31) begin
        full = 1;
        rst = en;
      end
    end
  endtask
  task reg_io(input logic w, input logic [11:0] a, input logic [7:0] d);
    logic [20:0] t;
    logic [31:0] e;
    @(posedge sys_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
    @(posedge sys_clk);
    penable <= 1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
    t = ptr ? stk[ptr] : 21'h0;
    case (a)
      12'h000: e = pc[7:0];
      12'h004: e = hiLatch;
      12'h008: e = upLatch;
      12'h00C: e = {full, unf, 1'b0, 5'(ptr)};
      12'h010: e = t[7:0];
      12'h014: e = t[15:8];
      12'h018: e = t[20:16];
      default: e = 0;
    endcase
    if (!w) chk(prdata, e);
    chk(pslverr, a > 12'h018);
    if (!w && a == 12'h000) {upLatch, hiLatch} = {3'h0, pc[20:8]};
    if (w) case (a)
      12'h000: pc = {upLatch[4:0], hiLatch, d[7:1], 1'b0};
      12'h004: hiLatch = d;
      12'h008: upLatch = {3'h0, d[4:0]};
      12'h00C: {ptr, full, unf} = {27'h0, d[4:0], full & d[7], unf & d[6]};
      12'h010: if (ptr) stk[ptr][7:0] = d;
      12'h014: if (ptr) stk[ptr][15:8] = d;
      12'h018: if (ptr) stk[ptr][20:16] = d[4:0];
      default: ;
    endcase
  endtask
  task op(input integer k, input logic f);
    logic [20:0] t;
    logic [23:0] c;
    logic h;
    t = 21'($random(seed)) & 21'h1FFFFE;
    c = 24'($random(seed));
    h = 1'($random(seed));
    @(posedge sys_clk);
    {strb, fastOption, jumpTarget, cur, intHighPriority} <= {7'h01 << k, f, t, c, h};
    @(posedge sys_clk);
    strb <= 0;
    rst = 0;
    case (k)
      0: pc = pc + 2;
      1: pc = t;
      2: begin
        if (ptr) ptr--;
        else {unf, rst} = {1'b1, en};
        pc = pc + 2;
      end
      3: begin
        push(pc);
        pc = pc + 2;
      end
      4: if (ptr) {pc, ptr} = {stk[ptr], ptr - 1};
      else {pc, unf, rst} = {21'h0, 1'b1, en};
      5: begin
        push(pc + 2);
        pc = t;
        if (f) sh = c;
      end
      default: begin
        push(pc);
        pc = h ? 21'h000008 : 21'h000018;
        sh = c;
      end
    endcase
    if (rst) {pc, ptr} = 0;
    @(negedge sys_clk);
    chk(programCounter, pc);
    chk(stackDeviceReset, rst);
    chk({stackFullFlag, stackUnderflowFlag}, {full, unf});
    chk(restoreValid, k == 4 && f);
    if (k == 4 && f) chk({restoreValid, restoreBus}, {1'b1, sh});
  endtask
  initial begin
    seed = 32'h26CBD0C8;
    {errors, check_count, ptr} = 0;
    {rstn, psel, penable, pwrite, fastOption, intHighPriority, en, full, unf} = 0;
    {paddr, pwdata, strb, jumpTarget, cur, sh, hiLatch, upLatch, pc} = 0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1;
    for (i = 0; i < 70; i++) begin
      k = {$random(seed)} % 7;
      if ((k == 2 || k == 4) && ptr == 0) k = 3;
      if (ptr > 28 && k > 2) k = 4;
      op(k, i[0]);
      reg_io(0, 12'(4 * (i % 8)), 0);
    end
    reg_io(0, 12'h01C, 0);
    chk(pslverr, 1'b1);
    reg_io(1, 12'h00C, 8'h00);
    for (i = 0; i < 33; i++) op(5, 0);
    reg_io(0, 12'h010, 0);
    // Ones must keep the flags but never raise a clear one
    reg_io(1, 12'h00C, 8'hDF);
    reg_io(0, 12'h00C, 0);
    reg_io(1, 12'h00C, 8'h1F);
    reg_io(1, 12'h010, 8'h5C);
    reg_io(1, 12'h014, 8'hA5);
    reg_io(1, 12'h018, 8'h13);
    reg_io(1, 12'h004, 8'h3C);
    reg_io(1, 12'h008, 8'h0B);
    op(4, 1);
    reg_io(0, 12'h004, 0);
    reg_io(1, 12'h000, 8'h77);
    op(2, 0);
    op(3, 0);
    op(0, 0);
    reg_io(1, 12'h00C, 8'h00);
    op(2, 0);
    op(4, 0);
    @(posedge sys_clk);
    en <= 1;
    op(4, 0);
    reg_io(1, 12'h00C, 8'h00);
    for (i = 0; i < 31; i++) op(5, 0);
    reg_io(1, 12'h00C, 8'h9F);
    for (i = 4; i < 7; i++) reg_io(0, 12'(4 * i), 0);
    results;
  end
endmodule
